/* hw/ssdc_chan.sv */
// one output channel: drive, short retry and open-load check
module ssdc_chan #(
    parameter int TIMER_W    = ssdc_pkg::TIMER_W,
    parameter int RETRY_CYC  = ssdc_pkg::RETRY_CYC,
    parameter int SENSE_CYC  = ssdc_pkg::SENSE_CYC,
    parameter int SETTLE_CYC = ssdc_pkg::SETTLE_CYC,
    parameter int BLANK_CYC  = ssdc_pkg::BLANK_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // command and sense
    input  wire logic cmdOn,
    input  wire logic shortDet,
    input  wire logic openDet,
    // drain and status
    output logic      drainOn,
    output logic      faultFlag
);
    localparam logic [TIMER_W-1:0] SENSE_END  = TIMER_W'(SENSE_CYC - 1);
    localparam logic [TIMER_W-1:0] WAIT_END   = TIMER_W'(RETRY_CYC - SENSE_CYC - 1);
    localparam logic [TIMER_W-1:0] SETTLE_END = TIMER_W'(SETTLE_CYC - 1);
    localparam logic [TIMER_W-1:0] BLANK_END  = TIMER_W'(BLANK_CYC - 1);

    ssdc_pkg::ssdc_chan_state_t state_q, state_d;
    logic [TIMER_W-1:0]         timer_q, timer_d;
    logic                       drain_q, drain_d;
    logic                       fault_q, fault_d;

    always_comb begin
        state_d = state_q;
        timer_d = timer_q + TIMER_W'(1);
        unique case (state_q)
            ssdc_pkg::CH_OFF_SETTLE: begin
                if (cmdOn) begin
                    state_d = ssdc_pkg::CH_ON_BLANK;
                    timer_d = '0;
                end else if (timer_q == SETTLE_END) begin
                    state_d = ssdc_pkg::CH_OFF_CHECK;
                end
            end
            ssdc_pkg::CH_OFF_CHECK: begin
                timer_d = '0;
                if (cmdOn) begin
                    state_d = ssdc_pkg::CH_ON_BLANK;
                end
            end
            ssdc_pkg::CH_ON_BLANK: begin
                if (!cmdOn) begin
                    state_d = ssdc_pkg::CH_OFF_SETTLE;
                    timer_d = '0;
                end else if (timer_q == BLANK_END) begin
                    state_d = ssdc_pkg::CH_ON_RUN;
                end
            end
            ssdc_pkg::CH_ON_RUN: begin
                timer_d = '0;
                if (!cmdOn) begin
                    state_d = ssdc_pkg::CH_OFF_SETTLE;
                end else if (shortDet) begin
                    state_d = ssdc_pkg::CH_PROT_WAIT;
                end
            end
            ssdc_pkg::CH_PROT_WAIT: begin
                if (!cmdOn) begin
                    state_d = ssdc_pkg::CH_OFF_SETTLE;
                    timer_d = '0;
                end else if (timer_q == WAIT_END) begin
                    state_d = ssdc_pkg::CH_PROT_SENSE;
                    timer_d = '0;
                end
            end
            ssdc_pkg::CH_PROT_SENSE: begin
                if (!cmdOn) begin
                    state_d = ssdc_pkg::CH_OFF_SETTLE;
                    timer_d = '0;
                end else if (timer_q == SENSE_END) begin
                    state_d = shortDet ? ssdc_pkg::CH_PROT_WAIT : ssdc_pkg::CH_ON_RUN;
                    timer_d = '0;
                end
            end
            // unused state codes fall back to a safe off state
            default: begin
                state_d = ssdc_pkg::CH_OFF_SETTLE;
                timer_d = '0;
            end
        endcase
        drain_d = (state_d == ssdc_pkg::CH_ON_BLANK) || (state_d == ssdc_pkg::CH_ON_RUN)
                  || (state_d == ssdc_pkg::CH_PROT_SENSE);
        // shorted while protected, or open load once the drain has settled
        fault_d = (state_d == ssdc_pkg::CH_PROT_WAIT) || (state_d == ssdc_pkg::CH_PROT_SENSE)
                  || ((state_d == ssdc_pkg::CH_OFF_CHECK) && openDet);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ssdc_pkg::CH_OFF_SETTLE;
            timer_q <= '0;
            drain_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            drain_q <= drain_d;
            fault_q <= fault_d;
        end
    end

    assign drainOn   = drain_q;
    assign faultFlag = fault_q;

endmodule : ssdc_chan

/* hw/ssdc_pkg.sv */
// shared constants and types for the six-channel serial drive controller
// Notes on behaviour
// - while select is low, input bits are sampled on rising serial clock, msb first
// - select rising copies the six most recent shifted bits into the drive buffer
// - a latched zero turns a channel off, a latched one turns it on
// - fault and over-temperature status are snapshotted when select falls
// - each output bit is the input bit xor the fault flag for that position
// - output advances to the next xor-ed bit on each rising serial clock
// - fault data sits only in the first eight output bits of any frame
// - select rises after the full frame; that edge latches data and re-arms capture
// - output drives only while select is low, released after select rises
// - a protected shorted channel repeats its sense pulse every 4 ms nominal
// - each sense pulse re-enables the channel for about 70 us
// - per-channel fault flag means shorted or open load on that channel
// - over-temperature sits at bit 6 of 8-bit frames, bit 14 of 16-bit frames
// - over-temperature is reported only and never changes any channel
// - open-load check starts about 70 us after a channel switches off
package ssdc_pkg;

    localparam int NUM_CHAN      = 6;
    localparam int SHIFT_W       = 16;
    localparam int FAULT_BITS    = 8;
    localparam int CNT_W         = 5;

    // timing, in ns, and derived counts at the core clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int SENSE_NS      = 70000;
    localparam int SENSE_CYC     = (SENSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_NS     = 70000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_NS      = 70000;
    localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_NS      = 4000000;
    localparam int RETRY_CYC     = RETRY_NS / CLK_PERIOD_NS;
    localparam int TIMER_W       = 18;

    // reset values
    localparam logic [NUM_CHAN-1:0] DRIVE_RESET = 6'h00;
    localparam logic [SHIFT_W-1:0]  SHIFT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0]    CNT_RESET   = 5'h00;

    typedef struct packed {
        logic                overTemp;
        logic [NUM_CHAN-1:0] chanFault;
    } ssdc_fault_t;

    localparam ssdc_fault_t FAULT_RESET = '0;

    typedef struct packed {
        logic sdoOut;
        logic sdoOe;
    } ssdc_sdo_t;

    typedef enum logic [2:0] {
        CH_OFF_SETTLE,
        CH_OFF_CHECK,
        CH_ON_BLANK,
        CH_ON_RUN,
        CH_PROT_WAIT,
        CH_PROT_SENSE
    } ssdc_chan_state_t;

endpackage : ssdc_pkg

/* hw/ssdc_sync2.sv */
// two-flop level synchroniser
module ssdc_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // level in and out
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;

endmodule : ssdc_sync2

/* hw/ssdc_top.sv */
// serial control and fault reporting port of the six-channel low-side driver
module ssdc_top #(
    parameter int NUM_CHAN  = ssdc_pkg::NUM_CHAN,
    parameter int RETRY_CYC = ssdc_pkg::RETRY_CYC,
    parameter int SENSE_CYC = ssdc_pkg::SENSE_CYC
) (
    // core clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // serial link, clocked by the host
    input  wire logic                sclk,
    input  wire logic                csN,
    input  wire logic                sdi,
    output logic                     sdoOut,
    output logic                     sdoOe,
    // analog sense inputs
    input  wire logic [NUM_CHAN-1:0] shortDet,
    input  wire logic [NUM_CHAN-1:0] openDet,
    input  wire logic                overTemp,
    // drain gate commands and status
    output logic [NUM_CHAN-1:0]      drainOn,
    output logic [NUM_CHAN-1:0]      driveBuf,
    output ssdc_pkg::ssdc_fault_t    faultReg
);
    localparam int SW = ssdc_pkg::SHIFT_W;
    localparam int CW = ssdc_pkg::CNT_W;

    // ---------------- link domain (sclk) ----------------
    // select high clears the frame state asynchronously: sclk is idle between frames
    logic [SW-1:0] shift_q, shift_d;
    logic [CW-1:0] bitCnt_q, bitCnt_d;
    logic          sdo_q, sdo_d;
    logic [7:0]    faultVec;
    logic          faultBit;

    // fault register is frozen for the whole frame, so it is static in this domain
    assign faultVec = {1'b0, faultReg.overTemp, faultReg.chanFault};

    always_comb begin
        shift_d  = {shift_q[SW-2:0], sdi};
        bitCnt_d = (bitCnt_q == '1) ? bitCnt_q : bitCnt_q + CW'(1);
        faultBit = 1'b0;
        if (bitCnt_q < CW'(ssdc_pkg::FAULT_BITS)) begin
            faultBit = faultVec[3'(3'd7 - bitCnt_q[2:0])];
        end
        sdo_d = sdi ^ faultBit;
    end

    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            bitCnt_q <= ssdc_pkg::CNT_RESET;
            sdo_q    <= 1'b0;
        end else begin
            bitCnt_q <= bitCnt_d;
            sdo_q    <= sdo_d;
        end
    end

    // shift contents must survive select rising until the core domain copies them
    always_ff @(posedge sclk) begin
        if (!csN) begin
            shift_q <= shift_d;
        end
    end

    // ---------------- core domain (clk) ----------------
    logic                  csHigh;
    logic                  csHighPrev_q, csHighPrev_d;
    logic                  csRise;
    logic [NUM_CHAN-1:0]   drive_q, drive_d;
    ssdc_pkg::ssdc_fault_t fault_q, fault_d;
    ssdc_pkg::ssdc_sdo_t   sdoCtl_q, sdoCtl_d;
    logic [NUM_CHAN-1:0]   chanFault;

    ssdc_sync2 #(
        .RESET_VAL (1'b1)
    ) u_csSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (csN),
        .syncOut (csHigh)
    );

    always_comb begin
        csHighPrev_d = csHigh;
        csRise       = csHigh && !csHighPrev_q;
        drive_d      = drive_q;
        if (csRise) begin
            // shift register is quiet here: sclk stopped before select rose
            drive_d = shift_q[NUM_CHAN-1:0];
        end
        fault_d = fault_q;
        if (csHigh) begin
            fault_d.overTemp  = overTemp;
            fault_d.chanFault = chanFault;
        end
        sdoCtl_d.sdoOe  = !csHigh;
        sdoCtl_d.sdoOut = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            csHighPrev_q <= 1'b1;
            drive_q      <= ssdc_pkg::DRIVE_RESET;
            fault_q      <= ssdc_pkg::FAULT_RESET;
            sdoCtl_q     <= '0;
        end else begin
            csHighPrev_q <= csHighPrev_d;
            drive_q      <= drive_d;
            fault_q      <= fault_d;
            sdoCtl_q     <= sdoCtl_d;
        end
    end

    // over-temperature feeds only the fault register, never the channels
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        ssdc_chan #(
            .TIMER_W    (ssdc_pkg::TIMER_W),
            .RETRY_CYC  (RETRY_CYC),
            .SENSE_CYC  (SENSE_CYC),
            .SETTLE_CYC (ssdc_pkg::SETTLE_CYC),
            .BLANK_CYC  (ssdc_pkg::BLANK_CYC)
        ) u_chan (
            .clk       (clk),
            .rst       (rst),
            .cmdOn     (drive_q[ch]),
            .shortDet  (shortDet[ch]),
            .openDet   (openDet[ch]),
            .drainOn   (drainOn[ch]),
            .faultFlag (chanFault[ch])
        );
    end

    assign sdoOut   = sdo_q;
    assign sdoOe    = sdoCtl_q.sdoOe;
    assign driveBuf = drive_q;
    assign faultReg = fault_q;

endmodule : ssdc_top

/* sim/ssdc_bench.sv */
// self-checking bench for the serial drive controller
module ssdc_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RETRY = 64;
    localparam int SENSE = 8;
    logic                  clk      = 1'b0;
    logic                  rst      = 1'b1;
    logic                  overTemp = 1'b0;
    logic [5:0]            shortDet = 6'h00;
    logic [5:0]            openDet  = 6'h00;
    logic                  sclk, csN, sdi, sdoOut, sdoOe, drove;
    logic [5:0]            drainOn, driveBuf;
    logic [15:0]           echo;
    ssdc_pkg::ssdc_fault_t faultReg;
    int                    fails     = 0;
    int                    tests_run = 0;
    int                    n;
    initial begin
        forever #12.5 clk = ~clk;
    end
    ssdc_top #(.RETRY_CYC(RETRY), .SENSE_CYC(SENSE)) dut (
        .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
        .sdoOe(sdoOe), .shortDet(shortDet), .openDet(openDet), .overTemp(overTemp),
        .drainOn(drainOn), .driveBuf(driveBuf), .faultReg(faultReg));
    ssdc_host_model host (
        .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe));
    task automatic tick(input int cnt);
        repeat (cnt) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic xfer(input logic [15:0] data, input int len, input logic [15:0] exp);
        host.frame(data, len, echo, drove);
        check("sdo drive", 16'(drove), 16'h0001);
        check("sdo echo", echo, exp);
        tick(4);
    endtask : xfer
    initial begin
        tick(6);
        rst = 1'b0;
        tick(1);
        check("reset buf", 16'(driveBuf), 16'h0000);
        check("reset fault", 16'(faultReg), 16'h0000);
        xfer(16'h002A, 8, 16'h002A);
        check("buf 8", 16'(driveBuf), 16'h002A);
        check("drain 8", 16'(drainOn), 16'h002A);
        overTemp = 1'b1;
        tick(10);
        check("temp live", 16'(faultReg), 16'h0040);
        xfer(16'h0015, 16, 16'h4015);
        check("drain temp", 16'(drainOn), 16'h0015);
        xfer(16'h003C, 12, 16'h043C);
        check("buf odd", 16'(driveBuf), 16'h003C);
        openDet = 6'h03;
        tick(2000);
        check("settle", 16'(faultReg.chanFault), 16'h0000);
        tick(1200);
        check("open load", 16'(faultReg.chanFault), 16'h0003);
        xfer(16'h003C, 16, 16'h433C);
        // faults clear while the frame runs; the echo keeps the snapshot
        fork
            xfer(16'h003C, 8, 16'h007F);
            begin
                #300;
                openDet  = 6'h00;
                overTemp = 1'b0;
            end
        join
        check("fault clear", 16'(faultReg), 16'h0000);
        xfer(16'h0001, 8, 16'h0001);
        check("buf one", 16'(driveBuf), 16'h0001);
        tick(2900);
        shortDet = 6'h01;
        tick(20);
        check("short off", 16'(drainOn), 16'h0000);
        check("short flag", 16'(faultReg.chanFault), 16'h0001);
        for (n = 0; n < 100 && drainOn[0] !== 1'b1; n++) tick(1);
        check("retry", 16'(n > 20 && n < 50), 16'h0001);
        for (n = 0; n < 20 && drainOn[0] === 1'b1; n++) tick(1);
        check("sense", 16'(n), 16'(SENSE));
        shortDet = 6'h00;
        tick(80);
        check("recover", 16'(drainOn), 16'h0001);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        tick(1);
        check("rerst", 16'(drainOn), 16'h0000);
        print_verdict();
    end
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule : ssdc_bench

/* sim/ssdc_host_model.sv */
// host side of the serial link: select, clock and data
module ssdc_host_model (
    // serial link
    output logic      sclk,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdoOut,
    input  wire logic sdoOe
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released line shows the inverse, so a late enable or an early release spoils the echo
    logic sdoLine;
    assign sdoLine = sdoOe ? sdoOut : ~sdoOut;
    // idle: select pulled up, data pulled down, clock parked
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end
    task automatic frame(input logic [15:0] data, input int len,
                         output logic [15:0] echo, output logic drove);
        echo  = '0;
        csN   = 1'b0;
        #150;
        drove = sdoOe;
        for (int k = len - 1; k >= 0; k--) begin
            sdi = data[k];
            #24;
            if (k < len - 1) echo[k + 1] = sdoLine;
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        sdi = 1'b0;
        #24;
        echo[0] = sdoLine;
        csN = 1'b1;
        #200;
    endtask : frame
endmodule : ssdc_host_model

/* sim/ssdc_top_asserts.sv */
// port checks for the serial drive controller
module ssdc_top_asserts #(
    parameter int NUM_CHAN  = ssdc_pkg::NUM_CHAN,
    parameter int RETRY_CYC = ssdc_pkg::RETRY_CYC,
    parameter int SENSE_CYC = ssdc_pkg::SENSE_CYC
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // serial link
    input wire logic                  csN,
    input wire logic                  sdoOe,
    // sense and drive
    input wire logic [NUM_CHAN-1:0]   shortDet,
    input wire logic                  overTemp,
    input wire logic [NUM_CHAN-1:0]   drainOn,
    input wire logic [NUM_CHAN-1:0]   driveBuf,
    input wire ssdc_pkg::ssdc_fault_t faultReg
);
    localparam int WAIT_LO  = RETRY_CYC - SENSE_CYC - 2;
    localparam int WAIT_HI  = RETRY_CYC - SENSE_CYC + 2;
    localparam int SENSE_LO = SENSE_CYC - 1;
    localparam int SENSE_HI = SENSE_CYC + 1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_prot_off;
        $fell(drainOn[0]) && driveBuf[0] && shortDet[0];
    endsequence
    // a retry pulse, not the first turn-on after a new command
    sequence s_sense_on;
        $rose(drainOn[0]) && $past(driveBuf[0], 2) && shortDet[0];
    endsequence
    property p_rst_clear;
        $fell(rst) |-> driveBuf == '0 && drainOn == '0 && faultReg == '0 && !sdoOe;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("not clear after reset");
    property p_oe_on; $fell(csN) |-> ##[1:4] sdoOe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("sdo not driven");
    property p_oe_off; $rose(csN) |-> ##[1:4] !sdoOe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo not released");
    property p_buf_move; $changed(driveBuf) |-> csN && $past(csN); endproperty
    a_buf_move: assert property (p_buf_move) else $error("buffer moved in frame");
    property p_drain; $changed(driveBuf) && shortDet == '0 |=> drainOn == driveBuf; endproperty
    a_drain: assert property (p_drain) else $error("drain not following");
    property p_freeze; sdoOe && $past(sdoOe) && $past(sdoOe, 2) |-> $stable(faultReg); endproperty
    a_freeze: assert property (p_freeze) else $error("fault moved in frame");
    property p_live; (csN && $stable(overTemp)) [*8] |-> faultReg.overTemp == overTemp; endproperty
    a_live: assert property (p_live) else $error("fault not live");
    property p_retry; s_prot_off |-> ##[WAIT_LO:WAIT_HI] drainOn[0]; endproperty
    a_retry: assert property (p_retry) else $error("retry period off");
    property p_sense; s_sense_on |-> ##[SENSE_LO:SENSE_HI] !drainOn[0]; endproperty
    a_sense: assert property (p_sense) else $error("sense pulse off");
endmodule : ssdc_top_asserts

bind ssdc_top ssdc_top_asserts #(
    .NUM_CHAN(NUM_CHAN), .RETRY_CYC(RETRY_CYC), .SENSE_CYC(SENSE_CYC)
) u_chk (
    .clk(clk), .rst(rst), .csN(csN), .sdoOe(sdoOe), .shortDet(shortDet),
    .overTemp(overTemp), .drainOn(drainOn), .driveBuf(driveBuf), .faultReg(faultReg)
);
